// File: two_wire_master_tx.sv
// Two-wire master transmitter with an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_tx (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output tw_pkg::resp_t    bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output tw_pkg::resp_t    rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             irq,
	output logic             master_rx_mode
);
	import tw_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_WAIT_FREE, S_START, S_BYTE, S_STOP, S_HOLD} state_t;

	// --------------------------------
	// Declarations
	// --------------------------------
	tw_bit_if    bi();
	state_t      state_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  awaddr_q;
	logic [7:0]  wdata_q;
	logic        wstrb_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	resp_t       bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [7:0]  rdata_q;
	resp_t       rresp_q;
	logic        flag_q;
	logic        acken_q;
	logic        sta_q;
	logic        sto_q;
	logic        wcol_q;
	logic        en_q;
	logic        ie_q;
	logic [7:0]  data_q;
	logic [7:0]  status_q;
	logic [1:0]  presc_q;
	logic        first_q;
	logic        restart_q;
	logic        arb_q;
	logic        after_q;
	logic        rx_mode_q;
	logic        irq_q;
	logic        lo_q;
	logic        busy_q;
	logic        sda_d_q;
	logic [1:0]  lines_s;
	logic        aw_take;
	logic        w_take;
	logic        aw_nxt;
	logic        w_nxt;
	logic        wr_fire;
	logic        wr_lane;
	logic [1:0]  wsel;
	logic        ctrl_wr;
	logic        data_wr;
	logic        stat_wr;
	logic        ar_take;
	logic        rv_nxt;
	logic [1:0]  rsel;
	logic [7:0]  ctrl_rd;
	logic [7:0]  stat_rd;
	logic [7:0]  rd_val;
	logic        flag_set;
	logic        sto_clr;
	logic        hold_go;
	logic        start_det;
	logic        stop_det;

	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		if (a == OFS_CTRL)
			reg_sel = SEL_CTRL;
		else if (a == OFS_STAT)
			reg_sel = SEL_STAT;
		else if (a == OFS_DATA)
			reg_sel = SEL_DATA;
		else
			reg_sel = SEL_NONE;
	endfunction

	// --------------------------------
	// Line sampling and bus-free watch
	// --------------------------------
	tw_sync2 u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_a    ({scl_i, sda_i}),
		.pin_s    (lines_s)
	);

	tw_bit_engine u_eng (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.bi       (bi.eng),
		.scl_s    (lines_s[1]),
		.sda_s    (lines_s[0]),
		.scl_oe   (scl_oe),
		.sda_oe   (sda_oe)
	);

	assign start_det = lines_s[1] & sda_d_q & ~lines_s[0];
	assign stop_det  = lines_s[1] & ~sda_d_q & lines_s[0];

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sda_d_q <= 1'b1;
			busy_q  <= 1'b0;
		end else begin
			sda_d_q <= lines_s[0];
			if (start_det)
				busy_q <= 1'b1;
			else if (stop_det)
				busy_q <= 1'b0;
		end
	end

	// --------------------------------
	// AXI4-Lite slave
	// --------------------------------
	assign aw_take = awvalid & awready_q;
	assign w_take  = wvalid & wready_q;
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign aw_nxt  = aw_take | (aw_have_q & ~wr_fire);
	assign w_nxt   = w_take | (w_have_q & ~wr_fire);
	assign wsel    = reg_sel(awaddr_q);
	// Registers live in byte lane 0 only
	assign wr_lane = wr_fire & wstrb_q;
	assign ctrl_wr = wr_lane & (wsel == SEL_CTRL);
	assign stat_wr = wr_lane & (wsel == SEL_STAT);
	assign data_wr = wr_lane & (wsel == SEL_DATA);
	assign ar_take = arvalid & arready_q;
	assign rv_nxt  = ar_take | (rvalid_q & ~rready);
	assign rsel    = reg_sel(araddr);
	assign ctrl_rd = {flag_q, acken_q, sta_q, sto_q, wcol_q, en_q, 1'b0, ie_q};
	assign stat_rd = {status_q[7:3], 1'b0, presc_q};
	assign rd_val  = (rsel == SEL_CTRL) ? ctrl_rd :
	                 (rsel == SEL_STAT) ? stat_rd :
	                 (rsel == SEL_DATA) ? data_q : 8'h00;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 8'h00;
			wstrb_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 8'h00;
			rresp_q   <= RESP_OKAY;
		end else begin
			aw_have_q <= aw_nxt;
			w_have_q  <= w_nxt;
			awready_q <= ~aw_nxt;
			wready_q  <= ~w_nxt;
			arready_q <= ~rv_nxt;
			rvalid_q  <= rv_nxt;
			if (aw_take)
				awaddr_q <= awaddr;
			if (w_take) begin
				wdata_q <= wdata[7:0];
				wstrb_q <= wstrb[0];
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_take) begin
				rdata_q <= rd_val;
				rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// --------------------------------
	// Control, status and data registers
	// --------------------------------
	assign flag_set = bi.done & ((state_q == S_START) | (state_q == S_BYTE));
	assign sto_clr  = bi.done & (state_q == S_STOP);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_q  <= CTRL_RST[CB_FLAG];
			acken_q <= CTRL_RST[CB_ACKEN];
			sta_q   <= CTRL_RST[CB_STA];
			sto_q   <= CTRL_RST[CB_STO];
			wcol_q  <= 1'b0;
			en_q    <= CTRL_RST[CB_EN];
			ie_q    <= CTRL_RST[CB_IE];
			data_q  <= DATA_RST;
			presc_q <= PRESC_RST;
		end else begin
			if (ctrl_wr) begin
				// ACKEN is stored for readback only; transmit mode ignores it
				acken_q <= wdata_q[CB_ACKEN];
				sta_q   <= wdata_q[CB_STA];
				en_q    <= wdata_q[CB_EN];
				ie_q    <= wdata_q[CB_IE];
			end
			// Software set beats the self-clear after STOP
			if (ctrl_wr)
				sto_q <= wdata_q[CB_STO];
			else if (sto_clr)
				sto_q <= 1'b0;
			// Hardware set wins over a clear in the same cycle
			if (flag_set)
				flag_q <= 1'b1;
			else if (ctrl_wr && wdata_q[CB_FLAG])
				flag_q <= 1'b0;
			if (data_wr && !flag_q) begin
				wcol_q <= 1'b1;
			end else if (data_wr) begin
				data_q <= wdata_q;
				wcol_q <= 1'b0;
			end
			if (stat_wr)
				presc_q <= wdata_q[1:0];
		end
	end

	// --------------------------------
	// Transfer sequencer
	// --------------------------------
	assign hold_go = (state_q == S_HOLD) & ~flag_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q   <= S_IDLE;
			status_q  <= ST_IDLE;
			bi.go     <= 1'b0;
			bi.op     <= OP_STOP;
			bi.tx     <= DATA_RST;
			first_q   <= 1'b0;
			restart_q <= 1'b0;
			arb_q     <= 1'b0;
			after_q   <= 1'b0;
			rx_mode_q <= 1'b0;
		end else begin
			bi.go <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (en_q && sta_q && !flag_q)
						state_q <= S_WAIT_FREE;
				end
				S_WAIT_FREE: begin
					if (!busy_q) begin
						bi.go     <= 1'b1;
						bi.op     <= OP_START;
						restart_q <= 1'b0;
						state_q   <= S_START;
					end
				end
				S_START: begin
					if (bi.done) begin
						status_q <= restart_q ? ST_RSTART : ST_START;
						first_q  <= 1'b1;
						state_q  <= S_HOLD;
					end
				end
				S_BYTE: begin
					if (bi.done) begin
						first_q <= 1'b0;
						state_q <= S_HOLD;
						if (bi.arb_lost) begin
							status_q <= ST_ARB;
							arb_q    <= 1'b1;
						end else if (first_q && bi.tx[0]) begin
							rx_mode_q <= 1'b1;
							status_q  <= bi.rx_nack ? ST_AR_NACK : ST_AR_ACK;
						end else if (first_q) begin
							rx_mode_q <= 1'b0;
							status_q  <= bi.rx_nack ? ST_AW_NACK : ST_AW_ACK;
						end else begin
							status_q <= bi.rx_nack ? ST_D_NACK : ST_D_ACK;
						end
					end
				end
				S_STOP: begin
					if (bi.done) begin
						rx_mode_q <= 1'b0;
						status_q  <= ST_IDLE;
						state_q   <= after_q ? S_WAIT_FREE : S_IDLE;
					end
				end
				default: begin
					// Nothing moves on the bus until the flag is cleared
					if (hold_go && arb_q) begin
						arb_q    <= 1'b0;
						status_q <= ST_IDLE;
						state_q  <= sta_q ? S_WAIT_FREE : S_IDLE;
					end else if (hold_go && sto_q) begin
						bi.go   <= 1'b1;
						bi.op   <= OP_STOP;
						after_q <= sta_q;
						state_q <= S_STOP;
					end else if (hold_go && sta_q) begin
						bi.go     <= 1'b1;
						bi.op     <= OP_RESTART;
						restart_q <= 1'b1;
						state_q   <= S_START;
					end else if (hold_go && !rx_mode_q) begin
						// Receive data phase lives elsewhere
						bi.go   <= 1'b1;
						bi.op   <= OP_BYTE;
						bi.tx   <= data_q;
						state_q <= S_BYTE;
					end
				end
			endcase
		end
	end

	// --------------------------------
	// Output registers
	// --------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
			lo_q  <= 1'b0;
		end else begin
			irq_q <= ie_q & flag_q;
			lo_q  <= 1'b0;
		end
	end

	assign awready        = awready_q;
	assign wready         = wready_q;
	assign bvalid         = bvalid_q;
	assign bresp          = bresp_q;
	assign arready        = arready_q;
	assign rvalid         = rvalid_q;
	assign rresp          = rresp_q;
	assign rdata          = {24'h00_0000, rdata_q};
	assign scl_o          = lo_q;
	assign sda_o          = lo_q;
	assign irq            = irq_q;
	assign master_rx_mode = rx_mode_q;

	// --------------------------------
	// Assertions
	// --------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_wait_start;
		(state_q == S_WAIT_FREE && !busy_q) |=> bi.go && bi.op == OP_START;
	endproperty
	a_wait_start: assert property (p_wait_start) else $error("START not issued on free bus");

	property p_start_code;
		(state_q == S_START && bi.done && !restart_q) |=> flag_q && status_q == ST_START;
	endproperty
	a_start_code: assert property (p_start_code) else $error("START status wrong");

	property p_suspend;
		$rose(bi.go) |-> $past(flag_q) == 1'b0;
	endproperty
	a_suspend: assert property (p_suspend) else $error("bus moved while flag set");

	property p_addr_code;
		(state_q == S_BYTE && bi.done && first_q && !bi.arb_lost && !bi.tx[0])
			|=> flag_q && status_q == ($past(bi.rx_nack) ? ST_AW_NACK : ST_AW_ACK);
	endproperty
	a_addr_code: assert property (p_addr_code) else $error("address status wrong");

	property p_arb_code;
		(state_q == S_BYTE && bi.done && bi.arb_lost) |=> flag_q && status_q == ST_ARB ##1 arb_q;
	endproperty
	a_arb_code: assert property (p_arb_code) else $error("arbitration status wrong");

	property p_wcol;
		(data_wr && !flag_q) |=> wcol_q && data_q == $past(data_q);
	endproperty
	a_wcol: assert property (p_wcol) else $error("collision write not dropped");

	property p_data_code;
		(state_q == S_BYTE && bi.done && !bi.arb_lost && !first_q)
			|=> flag_q && status_q == ($past(bi.rx_nack) ? ST_D_NACK : ST_D_ACK);
	endproperty
	a_data_code: assert property (p_data_code) else $error("data status wrong");

	property p_stop_clr;
		(sto_clr && !ctrl_wr) |=> !sto_q && !flag_q;
	endproperty
	a_stop_clr: assert property (p_stop_clr) else $error("stop request not cleared");

	property p_restart;
		(hold_go && !arb_q && sta_q && !sto_q) |=> bi.go && bi.op == OP_RESTART ##1 !bi.go;
	endproperty
	a_restart: assert property (p_restart) else $error("repeated START not issued");

	property p_irq;
		(ie_q && flag_q)[*2] |-> irq_q;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	c_start: cover property (state_q == S_START && bi.done);
	c_arb: cover property (bi.done && bi.arb_lost);
	c_stop_start: cover property (sto_clr && after_q);
	c_wcol: cover property (data_wr && !flag_q);
endmodule
`default_nettype wire

// File: tw_pkg.sv
// Shared constants and types for the two-wire master transmitter
package tw_pkg;
	// --------------------------------
	// Timing
	// --------------------------------
	localparam int CLK_NS  = 5;
	localparam int QTR_NS  = 1250;
	localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [8:0] QTR_LAST  = 9'(QTR_CYC - 1);
	localparam logic [3:0] BYTE_BITS = 4'h9;
	localparam logic [1:0] LINE_IDLE = 2'h3;
	// --------------------------------
	// Register map
	// --------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_STAT = 2'h1;
	localparam logic [1:0] SEL_DATA = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;
	localparam int CB_FLAG  = 7;
	localparam int CB_ACKEN = 6;
	localparam int CB_STA   = 5;
	localparam int CB_STO   = 4;
	localparam int CB_EN    = 2;
	localparam int CB_IE    = 0;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] DATA_RST  = 8'hff;
	localparam logic [1:0] PRESC_RST = 2'h0;
	// --------------------------------
	// Status codes
	// --------------------------------
	localparam logic [7:0] ST_START   = 8'h08;
	localparam logic [7:0] ST_RSTART  = 8'h10;
	localparam logic [7:0] ST_AW_ACK  = 8'h18;
	localparam logic [7:0] ST_AW_NACK = 8'h20;
	localparam logic [7:0] ST_D_ACK   = 8'h28;
	localparam logic [7:0] ST_D_NACK  = 8'h30;
	localparam logic [7:0] ST_ARB     = 8'h38;
	localparam logic [7:0] ST_AR_ACK  = 8'h40;
	localparam logic [7:0] ST_AR_NACK = 8'h48;
	localparam logic [7:0] ST_IDLE    = 8'hf8;
	// --------------------------------
	// Types
	// --------------------------------
	typedef logic [1:0] resp_t;
	localparam resp_t RESP_OKAY   = 2'h0;
	localparam resp_t RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {OP_START, OP_RESTART, OP_STOP, OP_BYTE} op_t;
endpackage

// File: tw_bit_if.sv
// Command and result link between the controller and the bit engine
`timescale 1ns/1ps
`default_nettype none
interface tw_bit_if;
	import tw_pkg::*;
	op_t        op;
	logic       go;
	logic [7:0] tx;
	logic       done;
	logic       rx_nack;
	logic       arb_lost;
	modport ctrl (output op, go, tx, input done, rx_nack, arb_lost);
	modport eng (input op, go, tx, output done, rx_nack, arb_lost);
endinterface
`default_nettype wire

// File: tw_sync2.sv
// Two-stage synchroniser for the bus line inputs
`timescale 1ns/1ps
`default_nettype none
module tw_sync2 (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] pin_a,
	output logic      [1:0] pin_s
);
	import tw_pkg::*;
	logic [1:0] meta_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_q <= LINE_IDLE;
			pin_s  <= LINE_IDLE;
		end else begin
			meta_q <= pin_a;
			pin_s  <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: tw_bit_engine.sv
// Bit engine: START, repeated START, STOP and 9-bit byte frames
`timescale 1ns/1ps
`default_nettype none
module tw_bit_engine (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	tw_bit_if.eng     bi,
	input  wire logic scl_s,
	input  wire logic sda_s,
	output logic      scl_oe,
	output logic      sda_oe
);
	import tw_pkg::*;
	logic        run_q;
	op_t         op_q;
	logic [8:0]  qcnt_q;
	logic [1:0]  qtr_q;
	logic [3:0]  bit_q;
	logic [8:0]  sh_q;
	logic [1:0]  want;
	logic        stall;
	logic        qtr_end;
	logic        bit_end;
	logic        last_bit;
	logic        lost;

	// Wanted line levels {scl, sda} per quarter
	function automatic logic [1:0] lines(input op_t op, input logic [1:0] q, input logic b);
		case (op)
			OP_START:   lines = (q == 2'h0) ? 2'h3 : (q == 2'h3) ? 2'h0 : 2'h2;
			OP_RESTART: lines = (q == 2'h0) ? 2'h1 : (q == 2'h1) ? 2'h3 : (q == 2'h2) ? 2'h2 : 2'h0;
			OP_STOP:    lines = (q == 2'h0) ? 2'h0 : (q == 2'h1) ? 2'h2 : 2'h3;
			default:    lines = {(q == 2'h1) || (q == 2'h2), b};
		endcase
	endfunction

	// MSB first, so the direction bit goes out last as sda level
	assign want     = lines(op_q, qtr_q, sh_q[8]);
	// Slave may hold scl low; the quarter waits for it
	assign stall    = want[1] & ~scl_s & (qtr_q != 2'h0);
	assign qtr_end  = run_q & ~stall & (qcnt_q == QTR_LAST);
	assign bit_end  = qtr_end & (qtr_q == 2'h3);
	assign last_bit = (op_q != OP_BYTE) || (bit_q == BYTE_BITS - 4'h1);
	assign lost     = qtr_end & (qtr_q == 2'h2) & (op_q == OP_BYTE) & (bit_q < 4'h8) & sh_q[8] & ~sda_s;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run_q       <= 1'b0;
			op_q        <= OP_STOP;
			qcnt_q      <= '0;
			qtr_q       <= 2'h0;
			bit_q       <= 4'h0;
			sh_q        <= '1;
			scl_oe      <= 1'b0;
			sda_oe      <= 1'b0;
			bi.done     <= 1'b0;
			bi.rx_nack  <= 1'b0;
			bi.arb_lost <= 1'b0;
		end else begin
			bi.done <= lost | (bit_end & last_bit);
			if (bi.go && !run_q) begin
				run_q       <= 1'b1;
				op_q        <= bi.op;
				sh_q        <= {bi.tx, 1'b1};
				qcnt_q      <= '0;
				qtr_q       <= 2'h0;
				bit_q       <= 4'h0;
				bi.arb_lost <= 1'b0;
			end else if (lost) begin
				run_q       <= 1'b0;
				bi.arb_lost <= 1'b1;
			end else if (run_q) begin
				if (!stall)
					qcnt_q <= qtr_end ? '0 : qcnt_q + 9'h1;
				if (qtr_end)
					qtr_q <= qtr_q + 2'h1;
				if (qtr_end && qtr_q == 2'h2 && bit_q == 4'h8)
					bi.rx_nack <= sda_s;
				if (bit_end) begin
					sh_q  <= {sh_q[7:0], 1'b1};
					bit_q <= bit_q + 4'h1;
					if (last_bit)
						run_q <= 1'b0;
				end
			end
			// Losing arbitration lets go of both lines at once
			if (lost) begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end else if (run_q) begin
				scl_oe <= ~want[1];
				sda_oe <= ~want[0];
			end
		end
	end
endmodule
`default_nettype wire

// File: tw_slave_model.sv
// Behavioural slave receiver for the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nack,
	output logic            pull,
	output logic [7:0]      rx
);
	int cnt = 0;
	initial pull = 1'b0;
	initial rx = 8'h00;
	// Any START or repeated START opens a fresh packet
	always @(negedge sda) if (scl) begin
		cnt = 0;
		pull = 1'b0;
	end
	// Direction bit lands in rx[0]
	always @(posedge scl) begin
		if (cnt < 8) rx = {rx[6:0], sda};
		cnt = cnt + 1;
	end
	// Ack slot: pull low unless told to refuse
	always @(negedge scl) begin
		if (cnt == 8) pull = !nack;
		else if (cnt == 9) begin
			pull = 1'b0;
			cnt = 0;
		end
	end
endmodule
`default_nettype wire

// File: test_two_wire_master_tx.sv
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_master_tx;
	import tw_pkg::*;
	logic        core_clk = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, nack = 0, rival = 0;
	logic [7:0]  awaddr = 0, araddr = 0, d, adr, rx;
	logic [31:0] wdata = 0, rdata, seed = 32'h5781;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe;
	logic        irq, master_rx_mode, pull;
	resp_t       bresp, rresp;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe | pull | rival);
	int          mismatches = 0, checks = 0;
	logic [33:0] rq[$], bq[$];
	logic [7:0]  cv[8] = '{8'ha5, 8'h85, 8'hc5, 8'h85, 8'ha5, 8'h85, 8'hb5, 8'h85};
	logic [7:0]  st[8] = '{8'h08, 8'h18, 8'h28, 8'h30, 8'h10, 8'h20, 8'h08, 8'h40};
	int          kd[8] = '{0, 1, 2, 2, 0, 1, 0, 3};
	logic        nk[8] = '{0, 0, 0, 1, 0, 1, 0, 0};
	two_wire_master_tx two_wire_master_tx_i (.core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .irq(irq), .master_rx_mode(master_rx_mode));
	tw_slave_model tw_slave_model_i (.scl(scl), .sda(sda), .nack(nack), .pull(pull), .rx(rx));
	initial forever #2.5 core_clk = ~core_clk;
	// ----------------------------
	// Helpers
	// ----------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input resp_t r);
		bq.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		fork
			begin do @(posedge core_clk); while (!awready); awvalid <= 0; end
			begin do @(posedge core_clk); while (!wready); wvalid <= 0; end
			begin do @(posedge core_clk); while (!bvalid); bready <= 0; end
		join
		// One idle edge keeps the next request off the edge that ended this one
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input resp_t r);
		rq.push_back({r, 24'h0, e});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		fork
			begin do @(posedge core_clk); while (!arready); arvalid <= 0; end
			begin do @(posedge core_clk); while (!rvalid); rready <= 0; end
		join
		@(posedge core_clk);
	endtask
	// Flag is watched through irq, kept enabled; bounded so a stall cannot hang
	task automatic wait_flag();
		chk(34'h0, {33'h0, irq});
		for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge core_clk);
		chk(34'h1, {33'h0, irq});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (rvalid === 1'b1 && rready) chk(rq.pop_front(), {rresp, rdata});
		if (bvalid === 1'b1 && bready) chk(bq.pop_front(), {bresp, 32'h0});
	end
	initial begin
		repeat (90000) @(posedge core_clk);
		mismatches++;
		report_and_stop();
	end
	// ----------------------------
	// Sequence
	// ----------------------------
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 0;
		repeat (2) @(posedge core_clk);
		rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
		rd(OFS_STAT, ST_IDLE, RESP_OKAY);
		rd(OFS_DATA, DATA_RST, RESP_OKAY);
		rd(8'h0c, 8'h00, RESP_SLVERR);
		wr(8'h0c, 8'h55, RESP_SLVERR);
		wr(OFS_DATA, 8'h5a, RESP_OKAY);
		rd(OFS_CTRL, 8'h08, RESP_OKAY);
		rd(OFS_DATA, DATA_RST, RESP_OKAY);
		d = rnd();
		adr = {d[7:1], 1'b0};
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			if (kd[i] == 1) d = adr;
			if (kd[i] == 3) d = adr | 8'h01;
			if (kd[i] != 0) wr(OFS_DATA, d, RESP_OKAY);
			nack <= nk[i];
			wr(OFS_CTRL, cv[i], RESP_OKAY);
			wait_flag();
			rd(OFS_STAT, st[i], RESP_OKAY);
			chk({33'h0, kd[i] == 3}, {33'h0, master_rx_mode});
			if (kd[i] != 0) chk({26'h0, d}, {26'h0, rx});
		end
		chk(34'h1, {33'h0, master_rx_mode});
		wr(OFS_CTRL, 8'h95, RESP_OKAY);
		repeat (1200) @(posedge core_clk);
		rd(OFS_STAT, ST_IDLE, RESP_OKAY);
		rd(OFS_CTRL, 8'h05, RESP_OKAY);
		chk(34'h3, {32'h0, sda, scl});
		chk(34'h0, {31'h0, master_rx_mode, scl_o, sda_o});
		// Rival master holds sda low, so the first address bit loses arbitration
		wr(OFS_CTRL, 8'ha5, RESP_OKAY);
		wait_flag();
		rival <= 1;
		wr(OFS_DATA, rnd() | 8'h80, RESP_OKAY);
		wr(OFS_CTRL, 8'h85, RESP_OKAY);
		wait_flag();
		rd(OFS_STAT, ST_ARB, RESP_OKAY);
		rival <= 0;
		wr(OFS_CTRL, 8'ha5, RESP_OKAY);
		wait_flag();
		rd(OFS_STAT, ST_START, RESP_OKAY);
		report_and_stop();
	end
endmodule
`default_nettype wire
